// file: inc/isp_cfg.svh
// isp_cfg.svh: constants of the serial port i2c slave
// assumes: included by bare name, inc/ on the include path
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
`define ISP_SDA_DLY_CYC   3'h7
`define ISP_BIT_LAST      4'h8
`define ISP_BIT_ACK       4'h9
`define ISP_OWN_ADDR_RST  7'h00
`define ISP_BUF_LIMIT_RST 8'hff
`endif

// file: inc/isp_pkg.sv
// isp_pkg: types of the serial port i2c slave
// assumes: compiled before the design files
`default_nettype none
package isp_pkg;
  typedef enum logic [1:0] {ISP_EV_RX, ISP_EV_TXC, ISP_EV_STOP} isp_ev_t;
  typedef enum logic [1:0] {ISP_IDLE, ISP_ADDR, ISP_DATA, ISP_SKIP} isp_state_t;
endpackage
`default_nettype wire

// file: verilog/isp_slave.sv
// isp_slave: byte oriented i2c slave with clock stretching, core side events
// assumes: link_clk oversamples the open-drain lines; pads resolve the wires
// Function
// - address byte done at eighth falling edge raises receive event, byte readable
// - address compared; match drives ack, clock held low into ninth bit
// - mismatch gives not-acknowledge and the slave drops out of the transfer
// - clock hold released once software services the address event
// - match enables stop and transmit-complete events, disables receive event
// - transmit-complete event at ninth falling edge of every addressed byte
// - address acknowledge released at first transmit-complete event
// - slave transmit samples master ack, loads next byte when acknowledged
// - slave receive stores each data byte and acknowledges it
// - stop raises stop event, disables data events, rearms address receive
// - stop resets sequencer, transmit shifter and transmit flags; receive shift, preload and event byte registers keep their values
// - transmit writes accepted only while empty flag reads zero
// - empty flag set at ninth rising edge when no byte is preloaded
// - transmit data preloaded one byte ahead at each event
// - zero to 255 data bytes, limit configurable
// - byte count past limit abandons transfer, releases both lines
// - msb first, bit clock from master serial clock line
// - transmit event source is transmission completed
// - data line changes delayed seven link clock cycles
// - clock wait outputs used; both lines open drain
`include "isp_cfg.svh"
`default_nettype none
module isp_slave (
  input  wire logic           core_clk,
  input  wire logic           resetn,
  input  wire logic           link_clk,
  input  wire logic           scl_i,
  output logic                scl_o,
  output logic                scl_oe,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe,
  input  wire logic [6:0]     own_addr,
  input  wire logic [7:0]     buffer_size_limit,
  input  wire logic           event_ack,
  input  wire logic           tx_wr,
  input  wire logic [7:0]     tx_data,
  output logic                rx_event,
  output logic                txc_event,
  output logic                stop_event,
  output isp_pkg::isp_ev_t    event_kind,
  output logic [7:0]          receive_buffer,
  output logic                addr_match,
  output logic                read_mode,
  output logic                master_ack,
  output logic                transmit_register_empty_flag,
  output logic                busy,
  output logic                event_pending
);
  import isp_pkg::*;

  // link domain
  logic       scl_s1_q, scl_s2_q, scl_p_q;
  logic       sda_s1_q, sda_s2_q, sda_p_q;
  logic [6:0] addr_s1_q, addr_s2_q, addr_q;
  logic [7:0] lim_s1_q, lim_s2_q, lim_q;
  logic       svc_s1_q, svc_s2_q, svc_s3_q;
  logic       txw_s1_q, txw_s2_q, txw_s3_q;
  isp_state_t state_q;
  logic [3:0] bit_q;
  logic [7:0] rxs_q, txs_q, hold_q, cnt_q;
  logic       hold_full_q, txe_q, mack_q;
  logic       match_q, rw_q, scl_hold_q, sda_want_q;
  logic       sda_drv_q;
  logic [2:0] dly_q;
  logic       ev_tgl_q, ev_match_q, ev_rw_q, ev_mack_q, link_busy_q;
  isp_ev_t    ev_kind_q;
  logic [7:0] ev_byte_q;
  logic       od_low_q;
  // core domain
  logic       ev_s1_q, ev_s2_q, ev_s3_q;
  logic       txe_s1_q, txe_s2_q, bsy_s1_q, bsy_s2_q;
  logic       svc_tgl_q, txw_tgl_q;
  logic [7:0] txw_data_q;
  logic       pend_q;
  logic       rx_ev_q, txc_ev_q, stop_ev_q;
  isp_ev_t    kind_q;
  logic [7:0] rbuf_q;
  logic       amatch_q, rmode_q, mack_c_q;

  logic scl_rise, scl_fall, start_det, stop_det;
  logic eighth_fall, ninth_rise, ninth_fall, svc_edge, txw_edge;
  logic ev_edge, active;

  assign scl_rise    = scl_s2_q & ~scl_p_q;
  assign scl_fall    = ~scl_s2_q & scl_p_q;
  assign start_det   = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_det    = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  assign active      = (state_q == ISP_ADDR) || (state_q == ISP_DATA);
  assign eighth_fall = active & scl_fall & (bit_q == `ISP_BIT_LAST);
  assign ninth_rise  = active & scl_rise & (bit_q == `ISP_BIT_LAST);
  assign ninth_fall  = active & scl_fall & (bit_q == `ISP_BIT_ACK);
  assign svc_edge    = svc_s2_q ^ svc_s3_q;
  assign txw_edge    = txw_s2_q ^ txw_s3_q;
  assign ev_edge     = ev_s2_q ^ ev_s3_q;

  // pin and control synchronisers, first stage read only by second
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_s1_q  <= 1'b1;
      scl_s2_q  <= 1'b1;
      scl_p_q   <= 1'b1;
      sda_s1_q  <= 1'b1;
      sda_s2_q  <= 1'b1;
      sda_p_q   <= 1'b1;
      svc_s1_q  <= 1'b0;
      svc_s2_q  <= 1'b0;
      svc_s3_q  <= 1'b0;
      txw_s1_q  <= 1'b0;
      txw_s2_q  <= 1'b0;
      txw_s3_q  <= 1'b0;
      addr_s1_q <= `ISP_OWN_ADDR_RST;
      addr_s2_q <= `ISP_OWN_ADDR_RST;
      lim_s1_q  <= `ISP_BUF_LIMIT_RST;
      lim_s2_q  <= `ISP_BUF_LIMIT_RST;
    end
    else
    begin
      scl_s1_q  <= scl_i;
      scl_s2_q  <= scl_s1_q;
      scl_p_q   <= scl_s2_q;
      sda_s1_q  <= sda_i;
      sda_s2_q  <= sda_s1_q;
      sda_p_q   <= sda_s2_q;
      svc_s1_q  <= svc_tgl_q;
      svc_s2_q  <= svc_s1_q;
      svc_s3_q  <= svc_s2_q;
      txw_s1_q  <= txw_tgl_q;
      txw_s2_q  <= txw_s1_q;
      txw_s3_q  <= txw_s2_q;
      // quasi static: change only while idle
      addr_s1_q <= own_addr;
      addr_s2_q <= addr_s1_q;
      lim_s1_q  <= buffer_size_limit;
      lim_s2_q  <= lim_s1_q;
    end
  end

  // protocol sequencer
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q     <= ISP_IDLE;
      bit_q       <= 4'h0;
      rxs_q       <= 8'h00;
      cnt_q       <= 8'h00;
      match_q     <= 1'b0;
      rw_q        <= 1'b0;
      scl_hold_q  <= 1'b0;
      sda_want_q  <= 1'b0;
      addr_q      <= `ISP_OWN_ADDR_RST;
      lim_q       <= `ISP_BUF_LIMIT_RST;
      ev_tgl_q    <= 1'b0;
      ev_kind_q   <= ISP_EV_RX;
      ev_byte_q   <= 8'h00;
      ev_match_q  <= 1'b0;
      ev_rw_q     <= 1'b0;
      ev_mack_q   <= 1'b0;
      link_busy_q <= 1'b0;
    end
    else if (stop_det && state_q != ISP_IDLE)
    begin
      state_q     <= ISP_IDLE;
      bit_q       <= 4'h0;
      cnt_q       <= 8'h00;
      match_q     <= 1'b0;
      rw_q        <= 1'b0;
      scl_hold_q  <= 1'b0;
      sda_want_q  <= 1'b0;
      link_busy_q <= 1'b0;
      if (match_q)
      begin
        ev_tgl_q   <= ~ev_tgl_q;
        ev_kind_q  <= ISP_EV_STOP;
        ev_match_q <= 1'b0;
      end
    end
    else if (start_det && state_q == ISP_IDLE)
    begin
      // a start inside a transfer is not followed
      state_q     <= ISP_ADDR;
      bit_q       <= 4'h0;
      addr_q      <= addr_s2_q;
      lim_q       <= lim_s2_q;
      link_busy_q <= 1'b1;
    end
    else
    begin
      if (svc_edge)
        scl_hold_q <= 1'b0;
      if (active && scl_rise && bit_q < `ISP_BIT_LAST)
        rxs_q <= {rxs_q[6:0], sda_s2_q};
      if (active && scl_rise)
        bit_q <= bit_q + 4'h1;
      if (ninth_fall)
        bit_q <= 4'h0;
      // next transmit bit, shifted msb first
      if (active && rw_q && match_q && scl_fall && bit_q != 4'h0 && bit_q < `ISP_BIT_LAST)
        sda_want_q <= ~txs_q[6];
      if (eighth_fall && state_q == ISP_ADDR)
      begin
        match_q    <= (rxs_q[7:1] == addr_q);
        rw_q       <= rxs_q[0];
        sda_want_q <= (rxs_q[7:1] == addr_q);
        scl_hold_q <= 1'b1;
        ev_tgl_q   <= ~ev_tgl_q;
        ev_kind_q  <= ISP_EV_RX;
        ev_byte_q  <= rxs_q;
        ev_match_q <= (rxs_q[7:1] == addr_q);
        ev_rw_q    <= rxs_q[0];
      end
      if (eighth_fall && state_q == ISP_DATA)
      begin
        if (cnt_q >= lim_q)
        begin
          state_q    <= ISP_SKIP;
          sda_want_q <= 1'b0;
          scl_hold_q <= 1'b0;
          link_busy_q <= 1'b0;
        end
        else
          sda_want_q <= ~rw_q;
      end
      if (ninth_fall && state_q == ISP_ADDR)
      begin
        if (match_q)
        begin
          state_q    <= ISP_DATA;
          sda_want_q <= rw_q & ~txs_q[7];
          scl_hold_q <= 1'b1;
          ev_tgl_q   <= ~ev_tgl_q;
          ev_kind_q  <= ISP_EV_TXC;
          ev_byte_q  <= rxs_q;
          ev_match_q <= 1'b1;
          ev_mack_q  <= 1'b0;
        end
        else
        begin
          state_q     <= ISP_SKIP;
          sda_want_q  <= 1'b0;
          link_busy_q <= 1'b0;
        end
      end
      if (ninth_fall && state_q == ISP_DATA)
      begin
        cnt_q      <= cnt_q + 8'h01;
        sda_want_q <= rw_q & mack_q & ~txs_q[7];
        scl_hold_q <= 1'b1;
        ev_tgl_q   <= ~ev_tgl_q;
        ev_kind_q  <= ISP_EV_TXC;
        ev_byte_q  <= rxs_q;
        ev_mack_q  <= mack_q;
      end
    end
  end

  // transmit shift register and one byte preload
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txs_q       <= 8'hff;
      hold_q      <= 8'hff;
      hold_full_q <= 1'b0;
      txe_q       <= 1'b0;
      mack_q      <= 1'b0;
    end
    else if (stop_det && state_q != ISP_IDLE)
    begin
      txs_q       <= 8'hff;
      hold_full_q <= 1'b0;
      txe_q       <= 1'b0;
      mack_q      <= 1'b0;
    end
    else
    begin
      if (active && rw_q && match_q && scl_fall && bit_q != 4'h0 && bit_q < `ISP_BIT_LAST)
        txs_q <= {txs_q[6:0], 1'b1};
      if (ninth_rise)
      begin
        mack_q <= ~sda_s2_q;
        // empty flag does not wait for the master's answer
        if (rw_q && match_q && !hold_full_q)
          txe_q <= 1'b1;
        else if (rw_q && match_q && (state_q == ISP_ADDR || !sda_s2_q))
        begin
          txs_q       <= hold_q;
          hold_full_q <= 1'b0;
        end
      end
      // a write landing with the load keeps its byte
      if (txw_edge)
      begin
        hold_q      <= txw_data_q;
        hold_full_q <= 1'b1;
      end
    end
  end

  // data line change delayed by a fixed count after the decision
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_drv_q <= 1'b0;
      dly_q     <= 3'h0;
      od_low_q  <= 1'b0;
    end
    else
    begin
      od_low_q <= 1'b0;
      if (sda_want_q == sda_drv_q)
        dly_q <= 3'h0;
      else if (dly_q == `ISP_SDA_DLY_CYC - 3'h1)
      begin
        sda_drv_q <= sda_want_q;
        dly_q     <= 3'h0;
      end
      else
        dly_q <= dly_q + 3'h1;
    end
  end

  // lines only ever pulled low, never driven high
  assign scl_oe = scl_hold_q;
  assign sda_oe = sda_drv_q;
  assign scl_o  = od_low_q;
  assign sda_o  = od_low_q;

  // core side: event capture and software handshake
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ev_s1_q  <= 1'b0;
      ev_s2_q  <= 1'b0;
      ev_s3_q  <= 1'b0;
      txe_s1_q <= 1'b0;
      txe_s2_q <= 1'b0;
      bsy_s1_q <= 1'b0;
      bsy_s2_q <= 1'b0;
    end
    else
    begin
      ev_s1_q  <= ev_tgl_q;
      ev_s2_q  <= ev_s1_q;
      ev_s3_q  <= ev_s2_q;
      txe_s1_q <= txe_q;
      txe_s2_q <= txe_s1_q;
      bsy_s1_q <= link_busy_q;
      bsy_s2_q <= bsy_s1_q;
    end
  end

  // payload held still by the stretched clock until serviced
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_ev_q   <= 1'b0;
      txc_ev_q  <= 1'b0;
      stop_ev_q <= 1'b0;
      kind_q    <= ISP_EV_RX;
      rbuf_q    <= 8'h00;
      amatch_q  <= 1'b0;
      rmode_q   <= 1'b0;
      mack_c_q  <= 1'b0;
    end
    else
    begin
      rx_ev_q   <= ev_edge && ev_kind_q == ISP_EV_RX;
      txc_ev_q  <= ev_edge && ev_kind_q == ISP_EV_TXC;
      stop_ev_q <= ev_edge && ev_kind_q == ISP_EV_STOP;
      if (ev_edge)
      begin
        kind_q   <= ev_kind_q;
        rbuf_q   <= ev_byte_q;
        amatch_q <= ev_match_q;
        rmode_q  <= ev_rw_q;
        mack_c_q <= ev_mack_q;
      end
    end
  end

  // service toggle only while an event waits; new event wins over ack
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_q    <= 1'b0;
      svc_tgl_q <= 1'b0;
    end
    else
    begin
      if (event_ack && pend_q)
      begin
        svc_tgl_q <= ~svc_tgl_q;
        pend_q    <= 1'b0;
      end
      if (ev_edge && ev_kind_q != ISP_EV_STOP)
        pend_q <= 1'b1;
    end
  end

  // transmit write crossing; refused once the shifter ran dry
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txw_tgl_q  <= 1'b0;
      txw_data_q <= 8'hff;
    end
    else if (tx_wr && !txe_s2_q)
    begin
      txw_tgl_q  <= ~txw_tgl_q;
      txw_data_q <= tx_data;
    end
  end

  assign rx_event                     = rx_ev_q;
  assign txc_event                    = txc_ev_q;
  assign stop_event                   = stop_ev_q;
  assign event_kind                   = kind_q;
  assign receive_buffer               = rbuf_q;
  assign addr_match                   = amatch_q;
  assign read_mode                    = rmode_q;
  assign master_ack                   = mack_c_q;
  assign transmit_register_empty_flag = txe_s2_q;
  assign busy                         = bsy_s2_q;
  assign event_pending                = pend_q;
endmodule
`default_nettype wire

// file: tb/isp_slave_checker.sv
// isp_slave_checker: core side event properties of the serial port i2c slave
// assumes: bound to isp_slave; sampled on core_clk, though scl_oe and the line outputs come from the link_clk domain
`default_nettype none
module isp_slave_checker (
  input wire logic             core_clk,
  input wire logic             resetn,
  input wire logic             scl_o,
  input wire logic             sda_o,
  input wire logic             scl_oe,
  input wire logic             busy,
  input wire logic             event_ack,
  input wire logic             rx_event,
  input wire logic             txc_event,
  input wire logic             stop_event,
  input wire isp_pkg::isp_ev_t event_kind,
  input wire logic             addr_match,
  input wire logic             read_mode,
  input wire logic             event_pending
);
  import isp_pkg::*;
  logic seen_q;
  logic seen_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // remembers whether the last address event matched, until stop
  assign seen_d = rx_event ? addr_match : (stop_event ? 1'b0 : seen_q);
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      seen_q <= 1'b0;
    else
      seen_q <= seen_d;
  rx_pulse_a: assert property (rx_event |=> !rx_event) else $error("rx pulse too long");
  event_excl_a: assert property ($onehot0({rx_event, txc_event, stop_event})) else $error("events overlap");
  rx_pending_a: assert property (rx_event |-> event_pending) else $error("no pending after rx");
  hold_wait_a: assert property (event_pending && !event_ack |=> event_pending) else $error("pending lost");
  ack_release_a: assert property (event_pending && event_ack && !rx_event && !txc_event |=> !event_pending)
    else $error("ack did not release");
  rx_kind_a: assert property (rx_event |-> event_kind == ISP_EV_RX) else $error("rx kind wrong");
  txc_kind_a: assert property (txc_event |-> event_kind == ISP_EV_TXC && addr_match)
    else $error("txc payload wrong");
  txc_match_a: assert property (txc_event |-> seen_q) else $error("txc without matched address");
  stop_clear_a: assert property (stop_event |-> event_kind == ISP_EV_STOP && !addr_match && seen_q)
    else $error("stop payload wrong");
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("line driven high");
  // hold is raised before the event crosses and dropped only after the ack crosses back
  pend_hold_a: assert property (event_pending |-> scl_oe) else $error("clock not held while pending");
  idle_free_a: assert property (!busy && !event_pending |-> !scl_oe) else $error("clock held while idle");
  cover property (rx_event && !addr_match);
  cover property (txc_event && read_mode);
  cover property (stop_event);
  cover property (event_pending && event_ack);
endmodule
bind isp_slave isp_slave_checker isp_slave_checker_i (.core_clk(core_clk), .resetn(resetn), .scl_o(scl_o),
  .sda_o(sda_o), .scl_oe(scl_oe), .busy(busy), .event_ack(event_ack), .rx_event(rx_event),
  .txc_event(txc_event), .stop_event(stop_event),
  .event_kind(event_kind), .addr_match(addr_match), .read_mode(read_mode), .event_pending(event_pending));
`default_nettype wire

// file: tb/isp_master.sv
// isp_master: behavioural i2c bus master pulling open-drain lines
// assumes: bench resolves both wires with pull-ups; link_clk paces bits
`default_nettype none
module isp_master (
  input  wire logic link_clk,
  input  wire logic scl,
  input  wire logic sda,
  output var logic  scl_pull,
  output var logic  sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // low phase covers the slave's sync flops and its seven cycle data delay
  localparam int HALF = 16;
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // slave may stretch; bounded so a stuck clock cannot hang the run
  task automatic rise;
    int w;
    begin
      w = 0;
      scl_pull <= 1'b0;
      tick(1);
      while (scl !== 1'b1 && w < 4000)
      begin
        tick(1);
        w++;
      end
    end
  endtask
  task automatic bit_io(input logic b, output logic r);
    begin
      tick(4);
      sda_pull <= !b;
      tick(HALF);
      rise;
      tick(HALF / 2);
      r = sda;
      tick(HALF / 2);
      scl_pull <= 1'b1;
    end
  endtask
  task automatic start;
    begin
      sda_pull <= 1'b1;
      tick(HALF);
      scl_pull <= 1'b1;
    end
  endtask
  // only start, bytes, stop: a repeated start is never issued
  task automatic stop;
    begin
      tick(4);
      sda_pull <= 1'b1;
      tick(HALF);
      rise;
      tick(HALF);
      sda_pull <= 1'b0;
      tick(HALF);
    end
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_i, output logic [7:0] q, output logic ack_o);
    logic r;
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bit_io(d[i], r);
        q[i] = r;
      end
      bit_io(ack_i, ack_o);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/isp_slave_test.sv
// isp_slave_test: drives the slave with a bus master and a software model
// assumes: isp_pkg compiled first; checker bound to the slave
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t %h %h", $time, a, b); end end
module isp_slave_test;
  import isp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, link_clk, resetn, event_ack, tx_wr, m_scl, m_sda, q_a;
  logic [6:0] own_addr;
  logic [7:0] buffer_size_limit, tx_data, q;
  logic       scl_o, scl_oe, sda_o, sda_oe, rx_event, txc_event, stop_event;
  logic       addr_match, read_mode, master_ack, flag, busy, event_pending;
  isp_ev_t    event_kind;
  logic [7:0] receive_buffer;
  wire logic  scl_w, sda_w;
  int         n_errors, cmp_count, n_rx, n_stop;
  logic [7:0] rbuf[$], txq[$];
  logic       amq[$], mkq[$];
  assign scl_w = (scl_oe ? scl_o : 1'b1) & !m_scl;
  assign sda_w = (sda_oe ? sda_o : 1'b1) & !m_sda;
  isp_slave isp_slave_i (.core_clk(core_clk), .resetn(resetn), .link_clk(link_clk), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .own_addr(own_addr),
    .buffer_size_limit(buffer_size_limit), .event_ack(event_ack), .tx_wr(tx_wr), .tx_data(tx_data),
    .rx_event(rx_event), .txc_event(txc_event), .stop_event(stop_event), .event_kind(event_kind),
    .receive_buffer(receive_buffer), .addr_match(addr_match), .read_mode(read_mode),
    .master_ack(master_ack), .transmit_register_empty_flag(flag), .busy(busy), .event_pending(event_pending));
  isp_master isp_master_i (.link_clk(link_clk), .scl(scl_w), .sda(sda_w), .scl_pull(m_scl), .sda_pull(m_sda));
  always #20 core_clk = ~core_clk;
  always #24 link_clk = ~link_clk;
  // software model: logs each event, preloads one byte ahead, then releases the hold
  always @(posedge core_clk)
  begin
    if (stop_event === 1'b1)
      n_stop++;
    if (rx_event === 1'b1 || txc_event === 1'b1)
    begin
      n_rx += (rx_event === 1'b1);
      rbuf.push_back(receive_buffer);
      amq.push_back(addr_match);
      mkq.push_back(master_ack);
      repeat (2) @(posedge core_clk);
      if (read_mode === 1'b1 && txq.size() > 0)
      begin
        tx_data <= txq.pop_front();
        tx_wr <= 1'b1;
        @(posedge core_clk);
        tx_wr <= 1'b0;
      end
      event_ack <= 1'b1;
      @(posedge core_clk);
      event_ack <= 1'b0;
    end
  end
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // short gap after stop stands in for the software re-arm time
  task setup(input logic [6:0] a, input logic [7:0] lim);
    begin
      @(posedge core_clk);
      own_addr <= a;
      buffer_size_limit <= lim;
      rbuf.delete();
      amq.delete();
      mkq.delete();
      n_rx = 0;
      n_stop = 0;
      repeat (8) @(posedge core_clk);
      isp_master_i.start;
    end
  endtask
  task settle;
    repeat (20) @(posedge core_clk);
  endtask
  task t_write;
    logic [7:0] e[4];
    begin
      e = '{8'ha4, 8'ha4, 8'ha5, 8'h3c};
      setup(7'h52, 8'h04);
      isp_master_i.xfer(8'ha4, 1'b1, q, q_a);
      `CHK(q_a, 1'b0)
      isp_master_i.xfer(8'ha5, 1'b1, q, q_a);
      `CHK(q, 8'ha5)
      `CHK(q_a, 1'b0)
      isp_master_i.xfer(8'h3c, 1'b1, q, q_a);
      isp_master_i.stop;
      settle;
      for (int i = 0; i < 4; i++)
        `CHK(rbuf[i], e[i])
      `CHK(n_rx, 1)
      `CHK(n_stop, 1)
      `CHK(event_kind, ISP_EV_STOP)
      `CHK(read_mode, 1'b0)
      $display("write test done");
    end
  endtask
  task t_mismatch;
    begin
      setup(7'h52, 8'hff);
      isp_master_i.xfer(8'h26, 1'b1, q, q_a);
      `CHK(q_a, 1'b1)
      isp_master_i.xfer(8'h00, 1'b1, q, q_a);
      `CHK(q_a, 1'b1)
      isp_master_i.stop;
      settle;
      `CHK(rbuf.size(), 1)
      `CHK(amq[0], 1'b0)
      `CHK(n_stop, 0)
      $display("mismatch test done");
    end
  endtask
  task t_read;
    begin
      txq = '{8'hc3, 8'h5a};
      setup(7'h52, 8'h04);
      isp_master_i.xfer(8'ha5, 1'b1, q, q_a);
      `CHK(q_a, 1'b0)
      isp_master_i.xfer(8'hff, 1'b0, q, q_a);
      `CHK(q, 8'hc3)
      isp_master_i.xfer(8'hff, 1'b1, q, q_a);
      `CHK(q, 8'h5a)
      settle;
      `CHK(flag, 1'b1)
      `CHK(read_mode, 1'b1)
      isp_master_i.stop;
      settle;
      `CHK(flag, 1'b0)
      `CHK(mkq[2], 1'b1)
      `CHK(mkq[3], 1'b0)
      `CHK(n_stop, 1)
      $display("read test done");
    end
  endtask
  task t_limit;
    begin
      setup(7'h52, 8'h01);
      isp_master_i.xfer(8'ha4, 1'b1, q, q_a);
      isp_master_i.xfer(8'h11, 1'b1, q, q_a);
      `CHK(q_a, 1'b0)
      isp_master_i.xfer(8'h22, 1'b1, q, q_a);
      `CHK(q_a, 1'b1)
      settle;
      `CHK(busy, 1'b0)
      `CHK({scl_oe, sda_oe}, 2'h0)
      `CHK(rbuf.size(), 3)
      isp_master_i.stop;
      $display("limit test done");
    end
  endtask
  initial
  begin
    #1000000;
    n_errors++;
    $display("watchdog expired");
    stop_test;
  end
  initial
  begin
    core_clk = 1'b0;
    link_clk = 1'b1;
    resetn = 1'b0;
    event_ack = 1'b0;
    tx_wr = 1'b0;
    tx_data = 8'h00;
    own_addr = 7'h00;
    buffer_size_limit = 8'hff;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK({scl_oe, sda_oe, flag, busy}, 4'h0)
    `CHK(receive_buffer, 8'h00)
    t_write;
    t_mismatch;
    t_read;
    t_limit;
    stop_test;
  end
endmodule
`undef CHK
`default_nettype wire
